// File: term_io_regs.vh
`ifndef TERM_IO_REGS_VH
`define TERM_IO_REGS_VH
// display memory window
`define DISP_BASE 16'h0400
`define DISP_LAST 16'h0B7F
`define DISP_COLS 80
`define DISP_ROWS 24
// switch bytes
`define SW_BANK_ONE 16'h0010
`define SW_BANK_TWO 16'h0011
`define SW_OPT_LOW 16'h0020
`define SW_OPT_HIGH 16'h0021
// window bases (upper address bits, low nibble free)
`define OCR_BASE 16'h0030
`define SIO_BASE 16'h0040
// output control bit addresses (low three bits)
`define OCR_TX_SERIAL 3'h0
`define OCR_TX_PERIPH 3'h1
`define OCR_PRN_CTS 3'h3
`define OCR_DTR 3'h4
`define OCR_WIDE 3'h5
`define OCR_BELL 3'h6
`define OCR_TIMER 3'h7
// serial register selects
`define SIO_SEL_DATA 2'h3
`define SIO_SEL_STAT 2'h2
`define SIO_SEL_MODE 2'h1
`define SIO_SEL_CMD 2'h0
// timing in ns, baud clock in kHz, 8 ns clock
`define CLK_NS 8
`define HSYNC_PERIOD_NS 53800
`define HSYNC_WIDTH_NS 5000
`define VSYNC_WIDTH_NS 600000
`define VSYNC_60_NS 16670000
`define VSYNC_50_NS 20000000
`define CHAR_CLK_NS 600
`define CLR_WIDTH_NS 1060
`define CLR_COUNT 10
`define BAUD_CLK_KHZ 5069
`endif

// File: terminal_io_address_decode.v
`timescale 1ns/10ps
`include "term_io_regs.vh"
module terminal_io_address_decode #(
   parameter VSYNC_60_CYC = `VSYNC_60_NS / `CLK_NS,
   parameter VSYNC_50_CYC = `VSYNC_50_NS / `CLK_NS,
   parameter VSYNC_W_CYC = `VSYNC_WIDTH_NS / `CLK_NS,
   parameter HSYNC_P_CYC = `HSYNC_PERIOD_NS / `CLK_NS,
   parameter HSYNC_W_CYC = `HSYNC_WIDTH_NS / `CLK_NS
) (
   // clock and reset
   input wire core_clk_i,
   input wire rstn_i,
   // cpu bus
   input wire [15:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   output wire disp_sel_o,
   output wire [10:0] disp_addr_o,
   // serial controller select
   output wire sio_cs_o,
   output wire sio_wr_o,
   output wire [1:0] sio_sel_o,
   input wire [7:0] sio_rdata_i,
   input wire sio_rx_irq_i,
   input wire sio_txd_i,
   input wire sio_tx_busy_i,
   // switches and strap
   input wire [7:0] sw_one_i,
   input wire [7:0] sw_two_i,
   input wire [3:0] sw_opt_low_i,
   input wire [3:0] sw_opt_high_i,
   input wire refresh_50_n_i,
   // control outputs
   output reg tx_serial_en_o,
   output reg tx_periph_en_o,
   output reg prn_cts_jam_o,
   output reg dtr_en_o,
   output reg wide_mode_o,
   output reg bell_on_o,
   output reg timer_reset_o,
   output wire [3:0] baud_code_o,
   output wire serial_txd_o,
   // refresh timing
   output reg char_clk_n_o,
   output reg clr_addr_n_o,
   output reg hsync_o,
   output reg vsync_n_o,
   output wire [6:0] char_col_o,
   // interrupt
   input wire timer_irq_i,
   output reg irq_n_o
);

   localparam [15:0] CHAR_P_CYC = `CHAR_CLK_NS / `CLK_NS;
   localparam [15:0] CLR_W_CYC = (`CLR_WIDTH_NS + `CLK_NS - 1) / `CLK_NS;
   localparam [6:0] LAST_COL = `DISP_COLS - 1;

   // pin inputs: three flops, a change counts once stages two and three agree
   localparam PIN_W = 27;
   // strap idles high, all other pins idle low
   localparam [PIN_W-1:0] PIN_INIT = {1'b1, 26'h000_0000};
   wire [PIN_W-1:0] pin_raw = {refresh_50_n_i, timer_irq_i, sio_rx_irq_i,
      sw_opt_high_i, sw_opt_low_i, sw_two_i, sw_one_i};
   wire [PIN_W-1:0] pin_clean;
   genvar g;
   generate
      for (g = 0; g < PIN_W; g = g + 1) begin : pin_sync
         reg [2:0] stage_reg;
         reg clean_reg;
         always @(posedge core_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               stage_reg <= {3{PIN_INIT[g]}};
               clean_reg <= PIN_INIT[g];
            end else begin
               stage_reg <= {stage_reg[1:0], pin_raw[g]};
               if (stage_reg[2] == stage_reg[1])
                  clean_reg <= stage_reg[2];
            end
         end
         assign pin_clean[g] = clean_reg;
      end
   endgenerate
   wire [7:0] sw_one_sync = pin_clean[7:0];
   wire [7:0] sw_two_sync = pin_clean[15:8];
   wire [3:0] sw_opt_low_sync = pin_clean[19:16];
   wire [3:0] sw_opt_high_sync = pin_clean[23:20];
   wire rx_evt = pin_clean[24];
   wire timer_evt = pin_clean[25];
   wire strap_n = pin_clean[26];

   // display window
   assign disp_sel_o = (addr_i >= `DISP_BASE) &&
      (addr_i <= `DISP_LAST);
   assign disp_addr_o = addr_i[10:0] - 11'h400;

   // serial window
   wire sio_hit = (addr_i[15:4] == `SIO_BASE >> 4);
   assign sio_cs_o = sio_hit && (rd_i || wr_i);
   assign sio_wr_o = sio_hit && wr_i;
   assign sio_sel_o = addr_i[1:0];
   assign serial_txd_o = sio_tx_busy_i ? sio_txd_i : 1'b1;
   assign baud_code_o = sw_one_sync[3:0];

   wire ocr_hit = (addr_i[15:4] == `OCR_BASE >> 4);

   // refresh rate from the filtered strap
   reg rate_50_reg;
   always @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rate_50_reg <= 1'b0;
      end else begin
         rate_50_reg <= ~strap_n;
      end
   end

   // output control latch
   always @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tx_serial_en_o <= 1'b0;
         tx_periph_en_o <= 1'b0;
         prn_cts_jam_o <= 1'b0;
         dtr_en_o <= 1'b0;
         wide_mode_o <= 1'b0;
         bell_on_o <= 1'b0;
         timer_reset_o <= 1'b0;
      end else if (ocr_hit && wr_i) begin
         case (addr_i[2:0])
            `OCR_TX_SERIAL: tx_serial_en_o <= wdata_i[0];
            `OCR_TX_PERIPH: tx_periph_en_o <= wdata_i[0];
            `OCR_PRN_CTS: prn_cts_jam_o <= wdata_i[0];
            `OCR_DTR: dtr_en_o <= wdata_i[0];
            `OCR_WIDE: wide_mode_o <= wdata_i[0];
            `OCR_BELL: bell_on_o <= ~wdata_i[0];
            `OCR_TIMER: timer_reset_o <= ~wdata_i[0];
            default: ;
         endcase
      end
   end

   // read mux
   always @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         if (sio_hit)
            rdata_o <= sio_rdata_i;
         else if (addr_i == `SW_BANK_ONE)
            rdata_o <= sw_one_sync;
         else if (addr_i == `SW_BANK_TWO)
            rdata_o <= sw_two_sync;
         else if (addr_i == `SW_OPT_LOW)
            rdata_o <= {4'h0, sw_opt_low_sync};
         else if (addr_i == `SW_OPT_HIGH)
            rdata_o <= {4'h0, sw_opt_high_sync};
         else
            rdata_o <= 8'h00;
      end
   end

   // character clock and column counter
   reg [15:0] char_div_reg;
   reg [6:0] col_reg;
   reg [15:0] line_cnt_reg;
   reg [15:0] clr_cnt_reg;
   wire char_tick = (char_div_reg == CHAR_P_CYC - 16'h0001);
   assign char_col_o = col_reg;

   // horizontal timing
   reg [15:0] h_cnt_reg;
   wire line_end = (h_cnt_reg == HSYNC_P_CYC - 1);
   always @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         h_cnt_reg <= 16'h0000;
         hsync_o <= 1'b0;
      end else begin
         h_cnt_reg <= line_end ? 16'h0000 : h_cnt_reg + 16'h0001;
         hsync_o <= (h_cnt_reg < HSYNC_W_CYC);
      end
   end

   // 80 character clocks per line, then idle
   always @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         char_div_reg <= 16'h0000;
         col_reg <= 7'h00;
         char_clk_n_o <= 1'b1;
         line_cnt_reg <= 16'h0000;
         clr_cnt_reg <= 16'h0000;
         clr_addr_n_o <= 1'b1;
      end else begin
         char_clk_n_o <= 1'b1;
         if (line_end) begin
            char_div_reg <= 16'h0000;
            col_reg <= 7'h00;
            line_cnt_reg <= line_cnt_reg + 16'h0001;
         end else if (col_reg <= LAST_COL && h_cnt_reg >= HSYNC_W_CYC) begin
            char_div_reg <= char_tick ? 16'h0000 : char_div_reg + 16'h0001;
            if (char_tick) begin
               char_clk_n_o <= 1'b0;
               col_reg <= col_reg + 7'h01;
            end
         end
         // end of display memory: clear pulse at the end of each of the first 10 lines of every 16
         if (line_end && line_cnt_reg[3:0] < `CLR_COUNT)
            clr_cnt_reg <= CLR_W_CYC;
         else if (clr_cnt_reg != 16'h0000)
            clr_cnt_reg <= clr_cnt_reg - 16'h0001;
         clr_addr_n_o <= (clr_cnt_reg == 16'h0000);
      end
   end

   // vertical timing
   reg [31:0] v_cnt_reg;
   wire [31:0] v_period = rate_50_reg ? VSYNC_50_CYC : VSYNC_60_CYC;
   always @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         v_cnt_reg <= 32'h0000_0000;
         vsync_n_o <= 1'b1;
      end else begin
         if (v_cnt_reg >= v_period - 32'h0000_0001)
            v_cnt_reg <= 32'h0000_0000;
         else
            v_cnt_reg <= v_cnt_reg + 32'h0000_0001;
         vsync_n_o <= ~(v_cnt_reg < VSYNC_W_CYC);
      end
   end

   // shared interrupt, one cycle low for each cycle in which either event rises
   reg timer_q_reg;
   reg rx_q_reg;
   always @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         timer_q_reg <= 1'b0;
         rx_q_reg <= 1'b0;
         irq_n_o <= 1'b1;
      end else begin
         timer_q_reg <= timer_evt;
         rx_q_reg <= rx_evt;
         irq_n_o <= ~((timer_evt & ~timer_q_reg) |
                      (rx_evt & ~rx_q_reg));
      end
   end

endmodule

// File: term_io_monitor.sv
`timescale 1ns/10ps
module term_io_monitor (
   input wire core_clk_i,
   input wire rstn_i,
   input wire [15:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire disp_sel_o,
   input wire [10:0] disp_addr_o,
   input wire sio_cs_o,
   input wire [1:0] sio_sel_o,
   input wire sio_tx_busy_i,
   input wire serial_txd_o,
   input wire wide_mode_o,
   input wire bell_on_o,
   input wire irq_n_o,
   input wire char_clk_n_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rstn_i);
   a_disp_range: assert property (disp_sel_o ==
      (addr_i >= 16'h0400 && addr_i <= 16'h0B7F)) else $error("bad select");
   a_disp_offset: assert property (disp_sel_o |->
      disp_addr_o == addr_i[10:0] - 11'h400) else $error("bad offset");
   a_sio_reg_sel: assert property (sio_cs_o |->
      sio_sel_o == addr_i[1:0] && addr_i[15:4] == 12'h004)
      else $error("bad serial select");
   a_wide_latch: assert property (wr_i && addr_i == 16'h0035 |=>
      wide_mode_o == $past(wdata_i[0])) else $error("wide not latched");
   a_bell_latch: assert property (wr_i && addr_i == 16'h0036 |=>
      bell_on_o != $past(wdata_i[0])) else $error("bell not latched");
   a_txd_idle: assert property (!sio_tx_busy_i |-> serial_txd_o)
      else $error("txd not idle high");
   a_irq_pulse: assert property ($fell(irq_n_o) |=> irq_n_o)
      else $error("irq pulse too long");
   a_char_pulse: assert property ($fell(char_clk_n_o) |=> char_clk_n_o)
      else $error("char clock pulse too long");
endmodule
bind terminal_io_address_decode term_io_monitor MON (.*);

// File: sio_ctrl_model.sv
`timescale 1ns/10ps
module sio_ctrl_model (
   input wire core_clk_i,
   input wire [1:0] sel_i,
   input wire send_i,
   output wire [7:0] rdata_o,
   output reg busy_o = 1'b0,
   output reg txd_o = 1'b1
);
   reg [3:0] cnt_reg = 4'h0;
   // each register answers its own select code
   assign rdata_o = {6'h30, sel_i};
   always @(posedge core_clk_i) begin
      if (send_i) begin
         busy_o <= 1'b1;
         txd_o <= 1'b0;
         cnt_reg <= 4'h9;
      end else if (busy_o) begin
         txd_o <= ~txd_o;
         cnt_reg <= cnt_reg - 4'h1;
         busy_o <= cnt_reg != 4'h0;
      end
   end
endmodule

// File: terminal_io_address_decode_tb.sv
`timescale 1ns/10ps
module terminal_io_address_decode_tb;
   logic core_clk_i, rstn_i, wr_i, rd_i, sio_rx_irq_i, refresh_50_n_i;
   logic timer_irq_i, send, sio_txd_i, sio_tx_busy_i, disp_sel_o, sio_cs_o;
   logic sio_wr_o, tx_serial_en_o, tx_periph_en_o, prn_cts_jam_o, dtr_en_o;
   logic wide_mode_o, bell_on_o, timer_reset_o, serial_txd_o, char_clk_n_o;
   logic clr_addr_n_o, hsync_o, vsync_n_o, irq_n_o;
   logic [15:0] addr_i;
   logic [7:0] wdata_i, rdata_o, sio_rdata_i, sw_one_i, sw_two_i, ctl;
   logic [10:0] disp_addr_o;
   logic [1:0] sio_sel_o;
   logic [3:0] sw_opt_low_i, sw_opt_high_i, baud_code_o;
   logic [6:0] char_col_o;
   int n_errors = 0, n_tests = 0, i, d, hi, ck, lo, cl;
   assign ctl = {timer_reset_o, bell_on_o, wide_mode_o, dtr_en_o,
      prn_cts_jam_o, 1'b0, tx_periph_en_o, tx_serial_en_o};
   terminal_io_address_decode #(.VSYNC_60_CYC(2000), .VSYNC_50_CYC(2400),
      .VSYNC_W_CYC(200)) DUT (.*);
   sio_ctrl_model peer (.core_clk_i(core_clk_i), .sel_i(sio_sel_o),
      .send_i(send), .rdata_o(sio_rdata_i), .busy_o(sio_tx_busy_i),
      .txd_o(sio_txd_i));
   initial begin
      core_clk_i = 0;
      forever #4 core_clk_i = ~core_clk_i;
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task acc(input logic [15:0] a, input logic [7:0] v, input logic w);
      @(negedge core_clk_i);
      addr_i = a;
      wdata_i = v;
      wr_i = w;
      rd_i = !w;
      @(negedge core_clk_i);
      wr_i = 0;
      rd_i = 0;
   endtask
   task span(input int n);
      {hi, ck, lo, cl} = 0;
      repeat (n) begin
         @(posedge core_clk_i);
         #1 hi += hsync_o;
         cl += !clr_addr_n_o;
         ck += !char_clk_n_o;
         lo += !vsync_n_o;
      end
   endtask
   task summarize;
      $display("checks %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      #400000;
      n_errors++;
      summarize();
   end
   initial begin
      {rstn_i, addr_i, wdata_i, wr_i, rd_i, send, timer_irq_i} = 0;
      {sio_rx_irq_i, refresh_50_n_i} = 2'b01;
      {sw_one_i, sw_two_i, sw_opt_low_i, sw_opt_high_i} = 24'hA5_3C96;
      repeat (5) @(negedge core_clk_i);
      rstn_i = 1;
      chk({ctl, irq_n_o, vsync_n_o}, 10'h003);
      for (i = 0; i < 8; i++)
         for (d = 0; d < 2; d++)
            if (i != 2) begin
               acc(16'h0030 + i, d, 1);
               chk(ctl[i], i > 5 ? !d : d);
            end
      acc(16'h0032, 8'h00, 1);
      chk(ctl, 8'h3B);
      acc(16'h0010, 0, 0);
      chk(rdata_o, 8'hA5);
      acc(16'h0011, 0, 0);
      chk(rdata_o, 8'h3C);
      acc(16'h0021, 0, 0);
      chk(rdata_o, 8'h06);
      acc(16'h0050, 0, 0);
      chk({rdata_o, baud_code_o}, 12'h005);
      for (i = 0; i < 4; i++) begin
         acc(16'h0040 + i, 0, 0);
         chk(rdata_o, 8'hC0 + i);
         @(negedge core_clk_i);
         addr_i = 16'h0044 + i;
         wr_i = 1;
         #1 chk({sio_cs_o, sio_wr_o, sio_sel_o}, 4'hC + i);
      end
      wr_i = 0;
      addr_i = 16'h0B7F;
      #1 chk({disp_sel_o, disp_addr_o}, 12'hF7F);
      addr_i = 16'h0B80;
      #1 chk(disp_sel_o, 0);
      send = 1;
      @(negedge core_clk_i) send = 0;
      chk(serial_txd_o, 0);
      repeat (12) @(negedge core_clk_i);
      chk(serial_txd_o, 1);
      for (i = 0; i < 2; i++) begin
         {sio_rx_irq_i, timer_irq_i} = 2'd1 << i;
         lo = 0;
         repeat (8) @(negedge core_clk_i) lo += !irq_n_o;
         chk(lo, 1);
      end
      @(posedge hsync_o) span(6725);
      chk(hi, 625);
      chk(ck, 80);
      chk(char_col_o, 0);
      @(negedge clr_addr_n_o) span(200);
      chk(cl, 132);
      @(negedge vsync_n_o) span(2000);
      chk(lo, 200);
      @(negedge core_clk_i) refresh_50_n_i = 0;
      repeat (2) @(negedge vsync_n_o);
      span(2400);
      chk(lo, 200);
      summarize();
   end
endmodule
